// file: logic/sched_defs.svh
`ifndef SCHED_DEFS_SVH
`define SCHED_DEFS_SVH
// sizes
`define NCPU 4
`define NSET 4
`define IDXW 2
`define CNTW 3
`define NWORD 5
// byte offsets
`define ADR_STAGE 8'h00
`define ADR_CMD 8'h14
`define ADR_RESULT 8'h18
`define ADR_IRQEN 8'h1C
`define ADR_CPU 8'h20
`define ADR_SET 8'h30
`define ADR_LSEL 8'h40
`define ADR_LOAD 8'h44
`define ADR_LOAD_END 8'h58
// command fields
`define CMD_OP_LSB 0
`define CMD_CPU_LSB 4
`define CMD_IDX_LSB 8
`define CMD_PRIV_BIT 12
// status fields
`define CPU_F_ALLOC 4
`define CPU_F_VV 5
`define SET_F_KIND 1
`define SET_F_LOCK 3
`define SET_F_CNT 8
// reset values
`define RST_WORD 32'h00000000
`define RST_VV 1'b1
`endif

// file: logic/sched_pkg.sv
package sched_pkg;
  typedef enum logic [2:0] {
    OP_POST = 3'b000, OP_SPAWN = 3'b001, OP_CLEAR = 3'b010, OP_WFORK = 3'b011,
    OP_JOIN = 3'b100, OP_IDLE = 3'b101, OP_SETIDX = 3'b110, OP_VVSET = 3'b111
  } op_t;
  typedef enum logic [1:0] {
    KIND_NONE = 2'b00, KIND_SINGLE = 2'b01, KIND_BCAST = 2'b10, KIND_HALTED = 2'b11
  } fork_kind_t;
  typedef enum logic {CPU_IDLE = 1'b0, CPU_ALLOC = 1'b1} cpu_state_t;
endpackage : sched_pkg

// file: logic/fork_arbiter.sv
`timescale 1ns/10ps
`include "sched_defs.svh"
module fork_arbiter (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // requests and grant
  input wire logic [`NCPU-1:0] req,
  output logic [`NCPU-1:0] grant
);
  import sched_pkg::*;
  logic [`IDXW-1:0] ptr_r;
  logic [`IDXW-1:0] idx;
  logic [`IDXW-1:0] win;
  logic found;

  // round robin from the one after the last winner onward
  always_comb begin
    grant = '0;
    found = 1'b0;
    idx = '0;
    win = '0;
    for (int i = 0; i < `NCPU; i++) begin
      idx = `IDXW'(ptr_r + `IDXW'(i));
      if (!found && req[idx]) begin
        grant[idx] = 1'b1;
        found = 1'b1;
        win = idx;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_r <= '0;
    end else if (found) begin
      ptr_r <= `IDXW'(win + `IDXW'(1));
    end
  end
endmodule : fork_arbiter

// file: logic/fork_set.sv
`timescale 1ns/10ps
`include "sched_defs.svh"
module fork_set (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // strobes
  input wire logic post,
  input wire sched_pkg::fork_kind_t post_kind,
  input wire logic clear,
  input wire logic halt,
  input wire logic inc,
  input wire logic dec,
  // start state in
  input wire logic [31:0] in_pc,
  input wire logic [31:0] in_sw,
  input wire logic [31:0] in_sp,
  input wire logic [31:0] in_fp,
  input wire logic [31:0] in_ap,
  // stored state out
  output logic posted,
  output sched_pkg::fork_kind_t kind,
  output logic [31:0] pc,
  output logic [31:0] sw,
  output logic [31:0] sp,
  output logic [31:0] fp,
  output logic [31:0] ap,
  output logic [`CNTW-1:0] count,
  output logic lock
);
  import sched_pkg::*;
  logic posted_r;
  fork_kind_t kind_r;
  logic [31:0] word_r [0:`NWORD-1];
  logic [`CNTW-1:0] count_r;
  logic lock_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      posted_r <= 1'b0;
      kind_r <= KIND_NONE;
      count_r <= '0;
      lock_r <= 1'b0;
      for (int w = 0; w < `NWORD; w++) begin
        word_r[w] <= `RST_WORD;
      end
    end else begin
      lock_r <= post | clear | halt | inc | dec;
      if (post) begin
        posted_r <= 1'b1;
        kind_r <= post_kind;
        word_r[0] <= in_pc;
        word_r[1] <= in_sw;
        word_r[2] <= in_sp;
        word_r[3] <= in_fp;
        word_r[4] <= in_ap;
      end else if (clear) begin
        posted_r <= 1'b0;
        kind_r <= KIND_NONE;
      end else if (halt && kind_r == KIND_BCAST) begin
        kind_r <= KIND_HALTED;
      end
      if (inc && !dec) begin
        count_r <= `CNTW'(count_r + `CNTW'(1));
      end else if (dec && !inc && count_r != '0) begin
        count_r <= `CNTW'(count_r - `CNTW'(1));
      end
    end
  end

  assign posted = posted_r;
  assign kind = kind_r;
  assign pc = word_r[0];
  assign sw = word_r[1];
  assign sp = word_r[2];
  assign fp = word_r[3];
  assign ap = word_r[4];
  assign count = count_r;
  assign lock = lock_r;
endmodule : fork_set

// file: logic/thread_fork_scheduler.sv
// Operation
// - fork request is cleared or posted
// - posting never stalls the posting processor
// - single post wants one, broadcast wants all
// - posting stores pc, status, stack, frame, argument
// - requests addressed through issuer's set index
// - idle processors scan every set for posts
// - taker loads set index and start state
// - single post cleared on take, broadcast stays
// - clear returns any posted request to cleared
// - wait-release ends thread, processor goes idle
// - conditional release idles unless last thread
// - set index write takes effect at once
// - processor is either allocated or idle
// - local events stay, interrupts go anywhere enabled
// - forced idle only in privileged mode
// - new thread clears vector valid flag
// - one lock bit per set serialises racing set access
// - first conditional release halts broadcast, last clears it
`timescale 1ns/10ps
`include "sched_defs.svh"
module thread_fork_scheduler (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // processor events
  input wire logic irq_req,
  input wire logic [`NCPU-1:0] local_evt,
  output logic [`NCPU-1:0] cpu_irq,
  output logic [`NCPU-1:0] cpu_trap,
  output logic [`NCPU-1:0] cpu_allocated
);
  import sched_pkg::*;

  // bus side state
  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rd;
  logic [31:0] stage_r [0:`NWORD-1];
  logic [2:0] result_r;
  logic [`NCPU-1:0] irq_en_r;
  logic [`IDXW-1:0] lsel_r;
  logic [`NCPU-1:0] irq_r;
  logic [`NCPU-1:0] trap_r;
  logic [`NCPU-1:0] alloc_out_r;

  // processor state
  cpu_state_t state_r [0:`NCPU-1];
  logic [`IDXW-1:0] sidx_r [0:`NCPU-1];
  logic [`IDXW-1:0] scan_r [0:`NCPU-1];
  logic [`NCPU-1:0] vv_r;
  logic [31:0] ctx_r [0:`NCPU-1][0:`NWORD-1];

  // set outputs
  logic set_posted [0:`NSET-1];
  fork_kind_t set_kind [0:`NSET-1];
  logic [31:0] set_word [0:`NSET-1][0:`NWORD-1];
  logic [`CNTW-1:0] set_count [0:`NSET-1];
  logic set_lock [0:`NSET-1];

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire bus_wr = bus_req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire hit_cmd = wb_adr_i == `ADR_CMD;
  wire hit_irqen = wb_adr_i == `ADR_IRQEN;
  wire hit_lsel = wb_adr_i == `ADR_LSEL;
  wire [7:0] load_ofs = 8'(wb_adr_i - `ADR_LOAD);
  wire cmd_fire = bus_wr & hit_cmd;

  // command fields
  op_t cmd_op;
  assign cmd_op = op_t'(wb_dat_i[`CMD_OP_LSB +: 3]);
  wire [`IDXW-1:0] cmd_cpu = wb_dat_i[`CMD_CPU_LSB +: `IDXW];
  wire [`IDXW-1:0] cmd_idx = wb_dat_i[`CMD_IDX_LSB +: `IDXW];
  wire cmd_priv = wb_dat_i[`CMD_PRIV_BIT];

  // command effects
  wire [`IDXW-1:0] cset = sidx_r[cmd_cpu];
  wire c_alloc = state_r[cmd_cpu] == CPU_ALLOC;
  wire is_last = set_count[cset] <= `CNTW'(1);
  wire is_post = cmd_op == OP_POST || cmd_op == OP_SPAWN;
  wire is_free = cmd_op == OP_SETIDX || cmd_op == OP_VVSET;
  wire priv_bad = cmd_op == OP_IDLE && !cmd_priv;
  wire refused = cmd_fire & (priv_bad | (~c_alloc & ~is_free));
  wire do_post = cmd_fire & c_alloc & is_post;
  wire do_clear = cmd_fire & c_alloc & (cmd_op == OP_CLEAR);
  wire do_wfork = cmd_fire & c_alloc & (cmd_op == OP_WFORK || (cmd_op == OP_IDLE && cmd_priv));
  wire do_join = cmd_fire & c_alloc & (cmd_op == OP_JOIN);
  wire join_rel = do_join & ~is_last;
  wire join_last = do_join & is_last;
  wire do_setidx = cmd_fire & (cmd_op == OP_SETIDX);
  wire do_vvset = cmd_fire & (cmd_op == OP_VVSET);
  wire cpu_leaves = do_wfork | join_rel | (do_setidx & c_alloc);
  fork_kind_t post_kind;
  assign post_kind = (cmd_op == OP_SPAWN) ? KIND_BCAST : KIND_SINGLE;

  // acceptance by scanning idle processors
  logic [`NCPU-1:0] acc_req;
  logic [`NCPU-1:0] acc_grant;
  logic [`IDXW-1:0] acc_cpu;
  wire acc_fire = |acc_grant;
  wire [`IDXW-1:0] acc_set = scan_r[acc_cpu];
  fork_kind_t acc_kind;
  assign acc_kind = set_kind[acc_set];

  always_comb begin
    acc_cpu = '0;
    for (int k = 0; k < `NCPU; k++) begin
      if (acc_grant[k]) begin
        acc_cpu = `IDXW'(k);
      end
    end
  end

  fork_arbiter u_acc_arb (
    .clock(clock),
    .rst(rst),
    .req(acc_req),
    .grant(acc_grant)
  );

  logic [`NCPU-1:0] irq_grant;
  fork_arbiter u_irq_arb (
    .clock(clock),
    .rst(rst),
    .req({`NCPU{irq_req}} & irq_en_r),
    .grant(irq_grant)
  );

  // register sets
  genvar g;
  generate
    for (g = 0; g < `NSET; g++) begin : g_set
      wire here = cset == `IDXW'(g);
      wire acc_here = acc_fire && acc_set == `IDXW'(g);
      fork_set u_set (
        .clock(clock),
        .rst(rst),
        .post(do_post & here),
        .post_kind(post_kind),
        .clear(((do_clear | join_last) & here) | (acc_here & acc_kind == KIND_SINGLE)),
        .halt(join_rel & here),
        .inc((do_setidx & cmd_idx == `IDXW'(g)) | acc_here),
        .dec(cpu_leaves & here),
        .in_pc(stage_r[0]),
        .in_sw(stage_r[1]),
        .in_sp(stage_r[2]),
        .in_fp(stage_r[3]),
        .in_ap(stage_r[4]),
        .posted(set_posted[g]),
        .kind(set_kind[g]),
        .pc(set_word[g][0]),
        .sw(set_word[g][1]),
        .sp(set_word[g][2]),
        .fp(set_word[g][3]),
        .ap(set_word[g][4]),
        .count(set_count[g]),
        .lock(set_lock[g])
      );
    end
  endgenerate

  // processors
  genvar k;
  genvar w;
  logic [31:0] cpu_rd [0:`NCPU-1];
  generate
    for (k = 0; k < `NCPU; k++) begin : g_cpu
      wire [`IDXW-1:0] sp = scan_r[k];
      wire mine = cmd_fire && cmd_cpu == `IDXW'(k);
      // a command blocks every take in its cycle, and the touched set's lock blocks takes on it the next cycle
      assign acc_req[k] = state_r[k] == CPU_IDLE && set_posted[sp] && set_kind[sp] != KIND_HALTED
                          && !set_lock[sp] && !cmd_fire;
      assign cpu_rd[k] = {26'h0, vv_r[k], state_r[k] == CPU_ALLOC, 2'h0, sidx_r[k]};

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          state_r[k] <= CPU_IDLE;
          sidx_r[k] <= '0;
          scan_r[k] <= '0;
          vv_r[k] <= `RST_VV;
        end else begin
          if (acc_grant[k]) begin
            state_r[k] <= CPU_ALLOC;
            sidx_r[k] <= acc_set;
            vv_r[k] <= 1'b0;
          end else if (mine) begin
            if (do_setidx) begin
              sidx_r[k] <= cmd_idx;
              state_r[k] <= CPU_ALLOC;
            end else if (do_wfork | join_rel) begin
              state_r[k] <= CPU_IDLE;
            end else if (do_vvset) begin
              vv_r[k] <= 1'b1;
            end
          end
          if (state_r[k] == CPU_IDLE && !acc_grant[k]) begin
            scan_r[k] <= `IDXW'(scan_r[k] + `IDXW'(1));
          end
        end
      end

      for (w = 0; w < `NWORD; w++) begin : g_ctx
        always_ff @(posedge clock or posedge rst) begin
          if (rst) begin
            ctx_r[k][w] <= `RST_WORD;
          end else if (acc_grant[k]) begin
            ctx_r[k][w] <= set_word[acc_set][w];
          end
        end
      end
    end
  endgenerate

  // set status words
  logic [31:0] set_rd [0:`NSET-1];
  generate
    for (g = 0; g < `NSET; g++) begin : g_srd
      assign set_rd[g] = {21'h0, set_count[g], 4'h0, set_lock[g], set_kind[g], set_posted[g]};
    end
  endgenerate

  // read select
  always_comb begin
    rd = '0;
    if (wb_adr_i < `ADR_CMD) begin
      rd = stage_r[wb_adr_i[4:2]];
    end else if (wb_adr_i == `ADR_RESULT) begin
      rd = {29'h0, result_r};
    end else if (wb_adr_i == `ADR_IRQEN) begin
      rd = {28'h0, irq_en_r};
    end else if (wb_adr_i >= `ADR_CPU && wb_adr_i < `ADR_SET) begin
      rd = cpu_rd[wb_adr_i[3:2]];
    end else if (wb_adr_i >= `ADR_SET && wb_adr_i < `ADR_LSEL) begin
      rd = set_rd[wb_adr_i[3:2]];
    end else if (wb_adr_i == `ADR_LSEL) begin
      rd = {30'h0, lsel_r};
    end else if (wb_adr_i >= `ADR_LOAD && wb_adr_i < `ADR_LOAD_END) begin
      rd = ctx_r[lsel_r][load_ofs[4:2]];
    end
  end

  // bus registers and outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
      result_r <= '0;
      irq_en_r <= '0;
      lsel_r <= '0;
      irq_r <= '0;
      trap_r <= '0;
      alloc_out_r <= '0;
    end else begin
      ack_r <= bus_req;
      rdat_r <= (bus_req && !wb_we_i) ? rd : 32'h00000000;
      if (cmd_fire) begin
        result_r <= {join_last, refused, ~refused};
      end
      if (bus_wr && hit_irqen) begin
        irq_en_r <= wb_dat_i[`NCPU-1:0];
      end
      if (bus_wr && hit_lsel) begin
        lsel_r <= wb_dat_i[`IDXW-1:0];
      end
      irq_r <= irq_grant;
      trap_r <= local_evt;
      for (int i = 0; i < `NCPU; i++) begin
        alloc_out_r[i] <= state_r[i] == CPU_ALLOC;
      end
    end
  end

  generate
    for (w = 0; w < `NWORD; w++) begin : g_stage
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          stage_r[w] <= `RST_WORD;
        end else if (bus_wr && wb_adr_i == 8'(`ADR_STAGE + 4 * w)) begin
          stage_r[w] <= (stage_r[w] & ~wmask) | (wb_dat_i & wmask);
        end
      end
    end
  endgenerate

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign cpu_irq = irq_r;
  assign cpu_trap = trap_r;
  assign cpu_allocated = alloc_out_r;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_post_marks_set: assert property (do_post |=> set_posted[$past(cset)])
    else $error("post did not mark set posted");
  a_post_no_stall: assert property (cmd_fire |=> wb_ack_o ##1 !wb_ack_o)
    else $error("command ack not single cycle");
  a_single_take_clears: assert property (acc_fire && acc_kind == KIND_SINGLE |=> !set_posted[$past(acc_set)])
    else $error("single request left posted");
  a_bcast_take_stays: assert property (acc_fire && acc_kind == KIND_BCAST |=> set_posted[$past(acc_set)])
    else $error("broadcast request dropped");
  a_take_binds_cpu: assert property (acc_fire |=> sidx_r[$past(acc_cpu)] == $past(acc_set)
                                     && state_r[$past(acc_cpu)] == CPU_ALLOC && !vv_r[$past(acc_cpu)])
    else $error("taker not bound");
  a_one_taker: assert property ($onehot0(acc_grant))
    else $error("request granted twice");
  a_forced_idle_priv: assert property (cmd_fire && priv_bad |=> result_r[1]
                                       && state_r[$past(cmd_cpu)] == $past(state_r[cmd_cpu]))
    else $error("unprivileged forced idle not refused");
  a_join_last_stays: assert property (join_last |=> !set_posted[$past(cset)] && state_r[$past(cmd_cpu)] == CPU_ALLOC
                                      && result_r[2])
    else $error("last thread release wrong");
  a_join_rel_halts: assert property (join_rel && set_kind[cset] == KIND_BCAST |=> set_kind[$past(cset)] == KIND_HALTED
                                     && state_r[$past(cmd_cpu)] == CPU_IDLE)
    else $error("release did not halt broadcast");
endmodule : thread_fork_scheduler

// file: tb/event_source.sv
`timescale 1ns/10ps
module event_source (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // requests from the bench
  input wire logic want_irq,
  input wire logic [3:0] want_evt,
  // event lines into the block
  output logic irq_req,
  output logic [3:0] local_evt
);
  // one cycle behind each request, quiet in reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
      local_evt <= 4'h0;
    end else begin
      irq_req <= want_irq;
      local_evt <= want_evt;
    end
  end
endmodule : event_source

// file: tb/tb.sv
`timescale 1ns/10ps
`include "sched_defs.svh"
module tb;
  import sched_pkg::*;
  logic clock, rst, cyc, stb, we, ack, want_irq, irq;
  logic [3:0] sel, want_evt, evt, irq_v, trap_v, alloc;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, r;
  logic [31:0] all_m;
  logic [3:0] msk;
  int err_count, tests_run, k;

  event_source ev_u (.clock(clock), .rst(rst), .want_irq(want_irq), .want_evt(want_evt),
    .irq_req(irq), .local_evt(evt));
  thread_fork_scheduler dut_u (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .irq_req(irq),
    .local_evt(evt), .cpu_irq(irq_v), .cpu_trap(trap_v), .cpu_allocated(alloc));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= msk;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : acc

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(r & m, exp);
  endtask : rd

  task cmd(input op_t op, input int cpu, input logic [1:0] idx, input logic priv);
    acc(1'b1, `ADR_CMD, {19'h0, priv, 2'h0, idx, 2'h0, 2'(cpu), 1'b0, op});
  endtask : cmd

  task wait_alloc(input int n);
    int c;
    c = 0;
    while ($countones(alloc) != n && c < 100) begin
      @(posedge clock);
      c++;
    end
    chk(32'($countones(alloc)), 32'(n));
  endtask : wait_alloc

  task pulse(input logic i, input logic [3:0] e);
    @(posedge clock);
    want_irq <= i;
    want_evt <= e;
    @(posedge clock);
    want_irq <= 1'b0;
    want_evt <= 4'h0;
    @(posedge clock);
    #1;
  endtask : pulse

  task t_reset;
    rd(`ADR_CPU, all_m, 32'h20);
    rd(`ADR_SET, all_m, 32'h0);
    acc(1'b1, 8'h80, 32'hFFFFFFFF);
    rd(8'h80, all_m, 32'h0);
    chk({28'h0, alloc}, 32'h0);
    msk = 4'h1;
    acc(1'b1, `ADR_STAGE, 32'hFFFFFFFF);
    msk = 4'hF;
    rd(`ADR_STAGE, all_m, 32'h000000FF);
    $display("test reset done");
  endtask : t_reset

  task t_bind;
    cmd(OP_SETIDX, 0, 2'h1, 1'b0);
    rd(`ADR_CPU, all_m, 32'h31);
    rd(`ADR_SET + 8'h04, 32'h700, 32'h100);
    $display("test bind done");
  endtask : t_bind

  task t_single;
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, `ADR_STAGE + 8'(4 * i), 32'hC0DE0000 + 32'(i));
    end
    cmd(OP_POST, 0, 2'h0, 1'b0);
    rd(`ADR_RESULT, all_m, 32'h1);
    wait_alloc(2);
    for (int j = 1; j < 4; j++) begin
      if (alloc[j] === 1'b1) k = j;
    end
    rd(`ADR_CPU + 8'(4 * k), all_m, 32'h11);
    rd(`ADR_SET + 8'h04, 32'h701, 32'h200);
    acc(1'b1, `ADR_LSEL, 32'(k));
    for (int i = 0; i < 5; i++) begin
      rd(`ADR_LOAD + 8'(4 * i), all_m, 32'hC0DE0000 + 32'(i));
    end
    cmd(OP_WFORK, k, 2'h0, 1'b0);
    wait_alloc(1);
    rd(`ADR_SET + 8'h04, 32'h700, 32'h100);
    $display("test single post done");
  endtask : t_single

  task t_bcast;
    cmd(OP_SPAWN, 0, 2'h0, 1'b0);
    wait_alloc(4);
    rd(`ADR_SET + 8'h04, 32'h707, 32'h405);
    cmd(OP_JOIN, 1, 2'h0, 1'b0);
    rd(`ADR_RESULT, all_m, 32'h1);
    wait_alloc(3);
    rd(`ADR_SET + 8'h04, 32'h707, 32'h307);
    cmd(OP_CLEAR, 0, 2'h0, 1'b0);
    rd(`ADR_SET + 8'h04, 32'h1, 32'h0);
    for (int j = 2; j < 4; j++) begin
      cmd(OP_JOIN, j, 2'h0, 1'b0);
      rd(`ADR_RESULT, all_m, 32'h1);
    end
    cmd(OP_JOIN, 0, 2'h0, 1'b0);
    rd(`ADR_RESULT, all_m, 32'h5);
    rd(`ADR_SET + 8'h04, 32'h701, 32'h100);
    chk({28'h0, alloc}, 32'h1);
    $display("test broadcast done");
  endtask : t_bcast

  task t_priv;
    cmd(OP_IDLE, 0, 2'h0, 1'b0);
    rd(`ADR_RESULT, all_m, 32'h2);
    chk({28'h0, alloc}, 32'h1);
    cmd(OP_IDLE, 0, 2'h0, 1'b1);
    rd(`ADR_RESULT, all_m, 32'h1);
    wait_alloc(0);
    rd(`ADR_SET + 8'h04, 32'h700, 32'h0);
    cmd(OP_VVSET, k, 2'h0, 1'b0);
    rd(`ADR_CPU + 8'(4 * k), all_m, 32'h21);
    $display("test forced idle done");
  endtask : t_priv

  task t_rerst;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(`ADR_CPU + 8'(4 * k), all_m, 32'h20);
    rd(`ADR_IRQEN, all_m, 32'h0);
    rd(`ADR_SET + 8'h04, all_m, 32'h0);
    chk({28'h0, alloc}, 32'h0);
    $display("test mid-run reset done");
  endtask : t_rerst

  task t_events;
    acc(1'b1, `ADR_IRQEN, 32'h4);
    pulse(1'b1, 4'h0);
    chk({28'h0, irq_v}, 32'h4);
    pulse(1'b0, 4'h2);
    chk({28'h0, trap_v}, 32'h2);
    $display("test events done");
  endtask : t_events

  task test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    want_irq = 1'b0;
    want_evt = 4'h0;
    all_m = 32'hFFFFFFFF;
    msk = 4'hF;
    err_count = 0;
    tests_run = 0;
    k = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_bind;
    t_single;
    t_bcast;
    t_priv;
    t_events;
    t_rerst;
    test_done;
  end

  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    test_done;
  end
endmodule : tb
